// File: hw/hdm_consts.svh
// Notes on behaviour
// - Harmonics evaluated from second to thirty-first
// - Thirty-two spectral components per channel
// - Power mode: harmonic power over fundamental power
// - Shared method selector, amplitude after reset
// - Method selector is static, not banked
// - Five channels: three phases, two residuals
// - Per-element enable, default enabled
// - Thresholds in 0.01 percent, default 10.00
// - Phase element picks up on any phase
// - Residual element uses its own channel
// - Drop-out below 97 percent of threshold
// - Setting groups swap live without stopping
// - Blocking input sampled at cycle start
// - Unblocked pick-up gives start, starts timer
// - Blocked pick-up gives blocked indication only
// - Late blocking clears start like drop-out
// - Status: normal, start, alarm or blocked
// - Definite-time delay, 5 ms steps, 10 s
// - Resettable start, alarm and blocked counters
//
// Constants of the harmonic distortion monitor: register map, reset
// values, scaling and timing. Included by the package and the top.
`ifndef HDM_CONSTS_SVH
`define HDM_CONSTS_SVH

// Register byte offsets on APB; group base as address bits 11:6
`define HDM_MODE_OFS 12'h000
`define HDM_STATUS_OFS 12'h004
`define HDM_CNTCLR_OFS 12'h008
`define HDM_CNT_BASE 12'h00C
`define HDM_THD_BASE 12'h020
`define HDM_GRP_BASE 6'h01
// Field positions of the status word
`define HDM_ST_START 2
`define HDM_ST_ALARM 5
`define HDM_ST_BLOCKED 8
`define HDM_ST_BLK 11
`define HDM_ST_BUSY 12
// Reset values
`define HDM_THR_RST 16'h03E8
`define HDM_DLY_RST 19'h0_07D0
`define HDM_EN_RST 3'h7
// Scaling, hysteresis, last bin and last channel
`define HDM_PWR_SCALE 64'h0000_0000_0000_2710
`define HDM_AMP_SCALE 64'h0000_0000_05F5_E100
`define HDM_HYS_NUM 24'h00_0061
`define HDM_HYS_DEN 24'h00_0064
`define HDM_LAST_BIN 5'h1F
`define HDM_LAST_CH 3'h4
// Timing: clock rate and delay step
`define HDM_CLK_HZ 20000000
`define HDM_STEP_MS 5
`define HDM_STEP_CYC ((`HDM_CLK_HZ / 1000) * `HDM_STEP_MS)

`endif

// File: hw/hdm_pkg.sv
// Types of the harmonic distortion monitor.
// Assumes hdm_consts.svh is on the include path.
`include "hdm_consts.svh"

package hdm_pkg;

  typedef enum logic [2:0] {HDM_IDLE, HDM_PREP, HDM_DIV, HDM_SQRT,
    HDM_EVAL} hdm_fsm_e;

  typedef enum logic [1:0] {HDM_NORMAL, HDM_START, HDM_ALARM,
    HDM_BLOCKED} hdm_status_e;

  typedef struct packed {
    logic mode;
    logic [1:0][2:0] en;
    logic [1:0][2:0][15:0] thr;
    logic [1:0][2:0][18:0] dly;
    hdm_fsm_e fsm;
    logic [2:0] ch;
    logic [4:0][36:0] sum;
    logic [4:0][15:0] fund;
    logic [63:0] num;
    logic [32:0] rem;
    logic [63:0] quo;
    logic [6:0] cnt;
    logic [15:0] root;
    logic [31:0] rad;
    logic [4:0][15:0] thd;
    logic blk_lat;
    logic [2:0] picked;
    logic [2:0] start;
    logic [2:0] alarm;
    logic [2:0] blocked;
    logic [2:0][35:0] tmr;
    hdm_status_e status;
    logic [2:0][15:0] evcnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hdm_state_s;

endpackage : hdm_pkg

// File: hw/hdm_top.sv
// Harmonic distortion monitor: spectrum intake, ratio computation,
// pick-up with hysteresis, blocking, delay timers, APB registers.
// Assumes a front end streaming spectral bins synchronous to clock_i.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "hdm_consts.svh"

module hdm_top
  import hdm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `HDM_STEP_CYC
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Spectrum stream and program cycle
  input wire logic cycle_start_i,
  input wire logic spec_valid_i,
  input wire logic [2:0] spec_chan_i,
  input wire logic [4:0] spec_bin_i,
  input wire logic [15:0] spec_mag_i,
  // Blocking and setting group
  input wire logic block_i,
  input wire logic group_sel_i,
  // Indications
  output logic [2:0] start_o,
  output logic [2:0] alarm_o,
  output logic [2:0] blocked_o,
  output logic [1:0] status_o
);

  hdm_state_s st, next_st;

  logic setup, acc_wr, hit, grp_hit, g, ge, load, adv, hi, lo, pk;
  logic [2:0] idx, clr, ld_ch, rise;
  logic [31:0] rd, den, sq;
  logic [32:0] rsh;
  logic [63:0] qn;
  logic [15:0] trial, rnew;
  logic [35:0] tgt;

  // Status word shared by readback
  logic [31:0] status_word;
  assign status_word = {19'h0_0000, st.fsm != HDM_IDLE, st.blk_lat,
    st.blocked, st.alarm, st.start, st.status};

  // Whole next state; one process keeps every transition in one place
  always_comb
  begin
    next_st = st;
    setup = psel_i & ~penable_i;
    acc_wr = psel_i & penable_i & pwrite_i & st.pready;
    g = paddr_i[5];
    idx = paddr_i[4:2];
    grp_hit = (paddr_i[11:6] == `HDM_GRP_BASE) && (idx != 3'h7)
      && (paddr_i[1:0] == 2'h0);
    clr = 3'h0;
    rd = 32'h0000_0000;
    hit = 1'b1;
    den = 32'(st.fund[st.ch]) * 32'(st.fund[st.ch]);
    rsh = {st.rem[31:0], st.num[63]};
    ge = rsh >= {1'b0, den};
    qn = {st.quo[62:0], ge};
    trial = st.root | (16'h0001 << st.cnt[3:0]);
    rnew = ((32'(trial) * 32'(trial)) <= st.rad) ? trial : st.root;
    load = 1'b0;
    ld_ch = st.ch;
    adv = 1'b0;
    hi = 1'b0;
    lo = 1'b1;
    pk = 1'b0;
    tgt = 36'h0_0000_0000;
    sq = 32'h0000_0000;
    rise = 3'h0;

    // Register readback decode, answered on the setup cycle
    if (grp_hit)
    begin
      if (idx == 3'h0)
        rd = {29'h0000_0000, st.en[g]};
      else if (idx <= 3'h3)
        rd = {16'h0000, st.thr[g][idx - 3'h1]};
      else
        rd = {13'h0000, st.dly[g][idx - 3'h4]};
    end
    else if (paddr_i == `HDM_MODE_OFS)
      rd = {31'h0000_0000, st.mode};
    else if (paddr_i == `HDM_STATUS_OFS)
      rd = status_word;
    else if (paddr_i == `HDM_CNTCLR_OFS)
      rd = 32'h0000_0000;
    else
    begin
      hit = 1'b0;
      for (int i = 0; i < 3; i++)
        if (paddr_i == `HDM_CNT_BASE + 12'(4 * i))
        begin
          rd = {16'h0000, st.evcnt[i]};
          hit = 1'b1;
        end
      for (int i = 0; i < 5; i++)
        if (paddr_i == `HDM_THD_BASE + 12'(4 * i))
        begin
          rd = {16'h0000, st.thd[i]};
          hit = 1'b1;
        end
    end

    // Zero-wait APB: pready rises in every access phase
    next_st.pready = setup;
    next_st.pslverr = setup & ~hit;
    if (setup)
      next_st.prdata = pwrite_i ? 32'h0000_0000 : rd;

    // Writes land at the access edge only
    if (acc_wr & hit)
    begin
      if (grp_hit)
      begin
        // Both banks writable at any time; live swap via group_sel_i
        if (idx == 3'h0)
          next_st.en[g] = pwdata_i[2:0];
        else if (idx <= 3'h3)
          next_st.thr[g][idx - 3'h1] = pwdata_i[15:0];
        else
          next_st.dly[g][idx - 3'h4] = pwdata_i[18:0];
      end
      else if (paddr_i == `HDM_MODE_OFS)
        next_st.mode = pwdata_i[0]; // Not banked
      else if (paddr_i == `HDM_CNTCLR_OFS)
        clr = pwdata_i[2:0];
    end

    // Blocking level latched once per program cycle
    if (cycle_start_i)
      next_st.blk_lat = block_i;

    case (st.fsm)
      HDM_IDLE:
      begin
        // Bin 0 is DC, bin 1 the fundamental, 2..31 harmonics
        if (cycle_start_i)
        begin
          next_st.sum = '0;
          next_st.fund = '0;
        end
        if (spec_valid_i && spec_chan_i <= `HDM_LAST_CH)
        begin
          sq = 32'(spec_mag_i) * 32'(spec_mag_i);
          if (spec_bin_i == 5'h01)
            next_st.fund[spec_chan_i] = spec_mag_i;
          else if (spec_bin_i >= 5'h02)
            next_st.sum[spec_chan_i] = next_st.sum[spec_chan_i]
              + {5'h00, sq};
          if (spec_chan_i == `HDM_LAST_CH && spec_bin_i == `HDM_LAST_BIN)
            next_st.fsm = HDM_PREP;
        end
      end
      HDM_PREP:
      begin
        load = 1'b1;
        ld_ch = 3'h0;
        next_st.fsm = HDM_DIV;
      end
      HDM_DIV:
      begin
        // One quotient bit per clock keeps the divider small
        next_st.rem = ge ? rsh - {1'b0, den} : rsh;
        next_st.num = st.num << 1;
        next_st.quo = qn;
        next_st.cnt = st.cnt + 7'h01;
        if (st.cnt == 7'h3F)
        begin
          if (den == 32'h0000_0000)
            qn = '1; // No fundamental: saturate
          if (st.mode)
          begin
            next_st.thd[st.ch] = (|qn[63:16]) ? 16'hFFFF : qn[15:0];
            adv = 1'b1;
          end
          else
          begin
            next_st.rad = (|qn[63:32]) ? 32'hFFFF_FFFF : qn[31:0];
            next_st.root = 16'h0000;
            next_st.cnt = 7'h0F;
            next_st.fsm = HDM_SQRT;
          end
        end
      end
      HDM_SQRT:
      begin
        // Root of the scaled power ratio gives amplitude ratio
        next_st.root = rnew;
        next_st.cnt = st.cnt - 7'h01;
        if (st.cnt == 7'h00)
        begin
          next_st.thd[st.ch] = rnew;
          adv = 1'b1;
        end
      end
      HDM_EVAL:
      begin
        for (int e = 0; e < 3; e++)
        begin
          hi = 1'b0;
          lo = 1'b1;
          for (int c = 0; c < 5; c++)
            if ((c < 3 && e == 0) || (c == e + 2 && e > 0))
            begin
              // Any phase picks up; all must fall to drop out
              hi = hi | (st.thd[c] > st.thr[group_sel_i][e]);
              lo = lo & ((24'(st.thd[c]) * `HDM_HYS_DEN)
                < (24'(st.thr[group_sel_i][e]) * `HDM_HYS_NUM));
            end
          pk = st.en[group_sel_i][e]
            & (st.picked[e] ? ~lo : hi);
          next_st.picked[e] = pk;
          next_st.start[e] = pk & ~st.blk_lat;
          next_st.blocked[e] = pk & st.blk_lat;
        end
        next_st.fsm = HDM_IDLE;
      end
      default:
        next_st.fsm = HDM_IDLE;
    endcase

    // Channel sequencing and divider load
    if (adv)
    begin
      if (st.ch == `HDM_LAST_CH)
        next_st.fsm = HDM_EVAL;
      else
      begin
        load = 1'b1;
        ld_ch = st.ch + 3'h1;
        next_st.fsm = HDM_DIV;
      end
    end
    if (load)
    begin
      next_st.ch = ld_ch;
      next_st.num = st.mode ? 64'(st.sum[ld_ch]) * `HDM_PWR_SCALE
        : 64'(st.sum[ld_ch]) * `HDM_AMP_SCALE;
      next_st.rem = 33'h0_0000_0000;
      next_st.quo = 64'h0000_0000_0000_0000;
      next_st.cnt = 7'h00;
    end

    // Definite-time timers restart whenever start is released
    for (int e = 0; e < 3; e++)
    begin
      tgt = 36'(st.dly[group_sel_i][e]) * 36'(STEP_CYCLES);
      if (!next_st.start[e] || !st.start[e])
        next_st.tmr[e] = 36'h0_0000_0000;
      else if (st.tmr[e] != '1)
        next_st.tmr[e] = st.tmr[e] + 36'h0_0000_0001;
      next_st.alarm[e] = next_st.start[e]
        & (next_st.tmr[e] >= tgt);
    end

    // Overall condition, alarm outranks start outranks blocked
    if (|next_st.alarm)
      next_st.status = HDM_ALARM;
    else if (|next_st.start)
      next_st.status = HDM_START;
    else if (|next_st.blocked)
      next_st.status = HDM_BLOCKED;
    else
      next_st.status = HDM_NORMAL;

    // Event counters; an event beats a simultaneous clear
    rise[0] = |(next_st.start & ~st.start);
    rise[1] = |(next_st.alarm & ~st.alarm);
    rise[2] = |(next_st.blocked & ~st.blocked);
    for (int k = 0; k < 3; k++)
      if (rise[k])
        next_st.evcnt[k] = clr[k] ? 16'h0001
          : st.evcnt[k] + 16'h0001;
      else if (clr[k])
        next_st.evcnt[k] = 16'h0000;
  end

  // State register
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st <= '0; // Amplitude mode, idle, normal
      st.en <= {2{`HDM_EN_RST}};
      st.thr <= {6{`HDM_THR_RST}};
      st.dly <= {6{`HDM_DLY_RST}};
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state flops
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign start_o = st.start;
  assign alarm_o = st.alarm;
  assign blocked_o = st.blocked;
  assign status_o = st.status;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_div_begin;
    st.fsm == HDM_PREP ##1 st.fsm == HDM_DIV;
  endsequence

  sequence s_eval;
    st.fsm == HDM_EVAL;
  endsequence

  mode_reset_a: assert property ($past(sys_rst_i) |-> !st.mode)
    else $error("method selector not amplitude after reset");

  div_length_a: assert property (s_div_begin |-> (st.fsm == HDM_DIV)[*8])
    else $error("divider left early");

  blk_sample_a: assert property (cycle_start_i |=>
    st.blk_lat == $past(block_i))
    else $error("blocking level not sampled at cycle start");

  blocked_eval_a: assert property (s_eval and st.blk_lat |=>
    st.start == 3'h0 && st.blocked == st.picked)
    else $error("blocked pick-up still started");

  start_eval_a: assert property (s_eval and !st.blk_lat |=>
    st.start == st.picked && st.blocked == 3'h0)
    else $error("unblocked pick-up did not start");

  disabled_a: assert property (s_eval and !st.en[group_sel_i][0] |=>
    !st.picked[0] && !st.start[0])
    else $error("disabled element picked up");

  res_pickup_a: assert property (s_eval and st.en[group_sel_i][1]
    and st.thd[3] > st.thr[group_sel_i][1] |=> st.picked[1])
    else $error("residual one missed pick-up");

  hold_band_a: assert property (s_eval and st.picked[2]
    and st.en[group_sel_i][2]
    and (24'(st.thd[4]) * `HDM_HYS_DEN
      >= 24'(st.thr[group_sel_i][2]) * `HDM_HYS_NUM) |=> st.picked[2])
    else $error("residual two dropped inside hysteresis band");

  alarm_start_a: assert property ((st.alarm & ~st.start) == 3'h0)
    else $error("alarm without start");

  status_alarm_a: assert property (|st.alarm |->
    st.status == HDM_ALARM)
    else $error("status not alarm");

  release_a: assert property ($fell(st.start[0]) |->
    !st.alarm[0] && st.tmr[0] == 36'h0_0000_0000)
    else $error("timer not released with start");

endmodule : hdm_top

// File: verification/hdm_fe_model.sv
// Front end model: streams one spectrum frame on request and drives
// the blocking level. Assumes the monitor is idle whenever go_i pulses.
`timescale 1ns/1ps

module hdm_fe_model
(
  // Clock and request from the bench
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic blk_i,
  input wire logic [4:0][15:0] harm_i,
  // Towards the monitor
  output logic cycle_start_o,
  output logic spec_valid_o,
  output logic [2:0] spec_chan_o,
  output logic [4:0] spec_bin_o,
  output logic [15:0] spec_mag_o,
  output logic block_o,
  output logic done_o
);
  int idx;

  // Phases carry their harmonic in bin 2, residuals in bin 31
  function automatic logic [15:0] mag(input logic [2:0] c,
    input logic [4:0] b);
    return (b == 5'h00) ? 16'hFFFF : (b == 5'h01) ? 16'h03E8 :
      (b == ((c < 3'h3) ? 5'h02 : 5'h1F)) ? harm_i[c] : 16'h0000;
  endfunction : mag

  // Idle magnitude toggles so a stale bin never looks valid
  initial
  begin
    cycle_start_o = 1'b0;
    spec_valid_o = 1'b0;
    spec_chan_o = 3'h0;
    spec_bin_o = 5'h00;
    spec_mag_o = 16'h5A5A;
    block_o = 1'b0;
    done_o = 1'b0;
    forever
    begin
      @(posedge clock_i);
      done_o <= 1'b0;
      spec_mag_o <= ~spec_mag_o;
      if (go_i)
      begin
        block_o <= blk_i; // Raised one clock ahead of the cycle start pulse
        @(posedge clock_i);
        cycle_start_o <= 1'b1;
        @(posedge clock_i);
        cycle_start_o <= 1'b0;
        block_o <= 1'b0; // Dropped once latched, so latching shows
        for (idx = 0; idx < 160; idx++)
        begin
          spec_valid_o <= 1'b1;
          spec_chan_o <= 3'(idx / 32);
          spec_bin_o <= 5'(idx % 32);
          spec_mag_o <= mag(3'(idx / 32), 5'(idx % 32));
          @(posedge clock_i);
        end
        spec_valid_o <= 1'b0;
        spec_mag_o <= 16'hA5A5;
        done_o <= 1'b1;
      end
    end
  end
endmodule : hdm_fe_model

// File: verification/tb.sv
// Testbench of the harmonic distortion monitor: a table of frames, then
// hand tests of delay, late blocking, counters, banks and reset.
// Assumes the design files and hdm_fe_model.sv are compiled first.
`timescale 1ns/1ps

module tb;
  typedef struct packed {
    logic mode;
    logic [2:0] en;
    logic blk;
    logic [4:0][15:0] harm;
    logic [2:0] st;
    logic [2:0] bk;
  } hdm_row_s;

  localparam int STEP = 4;
  // Fundamental is 1000, so amplitude gives 10*h, power h*h/100
  localparam hdm_row_s ROWS [9] = '{
    '{1'b0, 3'h7, 1'b0, {64'h0, 16'h0065}, 3'h1, 3'h0},
    '{1'b0, 3'h7, 1'b0, {32'h0, 16'h0062, 32'h0}, 3'h1, 3'h0},
    '{1'b0, 3'h7, 1'b0, {32'h0, 16'h0060, 32'h0}, 3'h0, 3'h0},
    '{1'b0, 3'h7, 1'b0, {48'h0, 16'h0064, 16'h0}, 3'h0, 3'h0},
    '{1'b0, 3'h7, 1'b0, {16'h0, 16'h0065, 48'h0}, 3'h2, 3'h0},
    '{1'b0, 3'h3, 1'b0, {16'h0065, 64'h0}, 3'h0, 3'h0},
    '{1'b0, 3'h7, 1'b1, {16'h0065, 64'h0}, 3'h0, 3'h4},
    '{1'b1, 3'h7, 1'b0, {64'h0, 16'h00C8}, 3'h0, 3'h0},
    '{1'b1, 3'h7, 1'b0, {64'h0, 16'h0190}, 3'h1, 3'h0}
  };

  logic clock_i, sys_rst_i, psel, penable, pwrite, group_sel, go, blk, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, cyc, sv, blk_w, e;
  logic [2:0] sch, start_o, alarm_o, blocked_o;
  logic [4:0] sbin;
  logic [15:0] smag;
  logic [4:0][15:0] harm;
  logic [1:0] status_o;
  hdm_row_s r;
  int failures, n_tests, cycles, run, h, k;

  hdm_top #(.STEP_CYCLES(STEP)) i_hdm_top (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .cycle_start_i(cyc), .spec_valid_i(sv), .spec_chan_i(sch),
    .spec_bin_i(sbin), .spec_mag_i(smag), .block_i(blk_w),
    .group_sel_i(group_sel), .start_o(start_o), .alarm_o(alarm_o),
    .blocked_o(blocked_o), .status_o(status_o));

  hdm_fe_model i_hdm_fe_model (.clock_i(clock_i), .go_i(go), .blk_i(blk),
    .harm_i(harm), .cycle_start_o(cyc), .spec_valid_o(sv),
    .spec_chan_o(sch), .spec_bin_o(sbin), .spec_mag_o(smag),
    .block_o(blk_w), .done_o(done));

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'b1);
    chk(32'(n), 32'h1, "pready wait");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Settings, one frame, then poll until the busy bit clears
  task automatic frame(input hdm_row_s f);
    apb(1'b1, 12'h000, {31'h0, f.mode});
    apb(1'b1, 12'h040, {29'h0, f.en});
    blk <= f.blk;
    harm <= f.harm;
    go <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    while (done !== 1'b1)
      @(posedge clock_i);
    do
      apb(1'b0, 12'h004, 32'h0);
    while (q[12] !== 1'b0);
  endtask : frame

  task automatic outs(input logic [2:0] st, input logic [2:0] bk,
    input logic [2:0] al, input logic [1:0] s);
    chk(32'(start_o), 32'(st), "start");
    chk(32'(blocked_o), 32'(bk), "blocked");
    chk(32'(alarm_o), 32'(al), "alarm");
    chk(32'(status_o), 32'(s), "status");
  endtask : outs

  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Hang guard and run length of the phase start indication
  always @(posedge clock_i)
  begin
    run <= start_o[0] ? run + 1 : 0;
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      $display("Error %0t: run did not finish", $time);
      conclude();
    end
  end

  initial
  begin
    {sys_rst_i, psel, penable, pwrite, group_sel, go, blk} = 7'h01 << 6;
    paddr = 12'h000;
    pwdata = 32'h0;
    harm = '0;
    {failures, n_tests, cycles, run} = '0;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      frame(ROWS[i]);
      for (int c = 0; c < 5; c++)
      begin
        h = int'(ROWS[i].harm[c]);
        apb(1'b0, 12'h020 + 12'(4 * c), 32'h0);
        chk(q, ROWS[i].mode ? 32'(h * h / 100) : 32'(h * 10), "thd");
      end
      outs(ROWS[i].st, ROWS[i].bk, 3'h0,
        (ROWS[i].st != 0) ? 2'h1 : (ROWS[i].bk != 0) ? 2'h3 : 2'h0);
    end
    // Alarm only after start held for 20 steps of STEP cycles
    frame(ROWS[2]);
    apb(1'b1, 12'h050, 32'h14);
    frame(ROWS[0]);
    k = 0;
    while (alarm_o[0] !== 1'b1 && k < 200)
    begin
      @(posedge clock_i);
      k++;
    end
    chk(32'(run), 32'(20 * STEP), "delay");
    @(posedge clock_i);
    outs(3'h1, 3'h0, 3'h1, 2'h2);
    // Block arriving while started clears start and alarm
    r = ROWS[0];
    r.blk = 1'b1;
    frame(r);
    outs(3'h0, 3'h1, 3'h0, 2'h3);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h4, "start count");
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'h1, "alarm count");
    apb(1'b0, 12'h014, 32'h0);
    chk(q, 32'h2, "blocked count");
    apb(1'b1, 12'h008, 32'h7);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h0, "cleared count");
    apb(1'b0, 12'h05C, 32'h0);
    chk({q[30:0], e}, 32'h1, "unmapped");
    // Second bank disabled; the shared method is set to power
    group_sel <= 1'b1;
    apb(1'b1, 12'h060, 32'h0);
    frame(ROWS[8]);
    outs(3'h0, 3'h0, 3'h0, 2'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h640, "bank thd");
    group_sel <= 1'b0;
    frame(ROWS[0]);
    // Reset in mid-run restores defaults
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    outs(3'h0, 3'h0, 3'h0, 2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h0, "mode");
    apb(1'b0, 12'h060, 32'h0);
    chk(q, 32'h7, "enable");
    apb(1'b0, 12'h044, 32'h0);
    chk(q, 32'h3E8, "threshold");
    apb(1'b0, 12'h050, 32'h0);
    chk(q, 32'h7D0, "delay");
    conclude();
  end
endmodule : tb
